// ---- wdt_top.sv ----
// Notes on behaviour
// - The watchdog is an 8-bit counter fed by an 11-bit prescaler at one twelfth of the clock.
// - The counter steps once per 12 times 2048 clock periods, one full prescaler wrap.
// - Counter overflow raises a short internal reset for the whole chip.
// - Overflow also drives a 3 machine cycle pulse out on the reset pin.
// - With the enable pin low the watchdog runs and software cannot stop it.
// - With the enable pin high the prescaler and counter still run, but overflow never resets.
// - A taken write to the counter clears load enable.
// - A counter write with load enable clear is ignored.
// - The counter counts up, so reload 00H is longest and 0FFH is shortest.
// - Prescaler and counter keep running in idle mode.
// - With the enable pin low, power control bit 1 cannot be set and stays 0.
// - The counter is a special function register at address 0FFH.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_top
  import wdt_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic WDT_ENABLE_N,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  output logic IDLE_MODE,
  output logic POWER_DOWN,
  output logic RESET_INTERNAL,
  output logic RESET_PIN_O,
  output logic RESET_PIN_OE
);
  logic [3:0] osc_div_r;
  logic [10:0] prescale_r;
  logic [7:0] pwrctl_r;
  logic [7:0] rdata_r;
  logic [1:0] pulse_cnt_r;
  logic int_rst_r;
  wdt_state_t state_r;
  logic tick;
  logic step;
  logic wr_count;
  logic wr_pwr;
  logic load;
  logic wrap;
  logic [7:0] count;
  logic chip_rst;
  logic [5:0] pulse_len_r;
  logic [14:0] step_gap_r;

  assign chip_rst = RST || int_rst_r;
  assign tick = (osc_div_r == `WDT_OSC_DIV);
  assign step = tick && (prescale_r == `WDT_PRESCALE_MAX);
  assign wr_count = SFR_WR && (SFR_ADDR == `WDT_ADDR_COUNT);
  assign wr_pwr = SFR_WR && (SFR_ADDR == `WDT_ADDR_PWRCTL);
  assign load = wr_count && pwrctl_r[`WDT_BIT_LOAD_EN];

  // Divide by twelve, cleared by pin reset only to keep pin pulse exact
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      osc_div_r <= 4'h0;
    end else begin
      osc_div_r <= tick ? 4'h0 : osc_div_r + 4'h1;
    end
  end

  // 11-bit prescaler; idle does not stop it
  always_ff @(posedge CLK_SYS or posedge chip_rst) begin
    if (chip_rst) begin
      prescale_r <= 11'h000;
    end else if (tick) begin
      prescale_r <= prescale_r + 11'h001;
    end
  end

  wdt_count_reg u_count (
    .clk(CLK_SYS),
    .rst(chip_rst),
    .load(load),
    .load_data(SFR_WDATA),
    .inc(step),
    .count(count),
    .wrap(wrap)
  );

  // Power control register
  always_ff @(posedge CLK_SYS or posedge chip_rst) begin
    if (chip_rst) begin
      pwrctl_r <= `WDT_PWRCTL_RESET;
    end else if (wr_pwr) begin
      pwrctl_r <= SFR_WDATA;
      if (!WDT_ENABLE_N) begin
        pwrctl_r[`WDT_BIT_PWR_DOWN] <= 1'b0;
      end
    end else if (load) begin
      pwrctl_r[`WDT_BIT_LOAD_EN] <= 1'b0;
    end
  end

  // Overflow: internal reset plus pin pulse of three machine cycles
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_r <= WDT_RUN;
      pulse_cnt_r <= 2'h0;
      int_rst_r <= 1'b0;
    end else begin
      int_rst_r <= 1'b0;
      unique case (state_r)
        WDT_RUN: begin
          if (wrap && !WDT_ENABLE_N) begin
            state_r <= WDT_PULSE;
            pulse_cnt_r <= 2'h0;
            int_rst_r <= 1'b1;
          end
        end
        WDT_PULSE: begin
          if (tick) begin
            if (pulse_cnt_r == `WDT_PULSE_MCYCLES - 2'h1) begin
              state_r <= WDT_RUN;
            end else begin
              pulse_cnt_r <= pulse_cnt_r + 2'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rdata_r <= 8'h00;
    end else if (SFR_RD) begin
      unique case (SFR_ADDR)
        `WDT_ADDR_COUNT: rdata_r <= count;
        `WDT_ADDR_PWRCTL: rdata_r <= pwrctl_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign SFR_RDATA = rdata_r;
  assign IDLE_MODE = pwrctl_r[`WDT_BIT_IDLE];
  assign POWER_DOWN = pwrctl_r[`WDT_BIT_PWR_DOWN];
  assign RESET_INTERNAL = int_rst_r;
  assign RESET_PIN_O = (state_r == WDT_PULSE);
  assign RESET_PIN_OE = (state_r == WDT_PULSE);

  // Assertion helper: clocks spent driving the reset pin
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pulse_len_r <= 6'h00;
    end else if (RESET_PIN_OE) begin
      pulse_len_r <= pulse_len_r + 6'h01;
    end else begin
      pulse_len_r <= 6'h00;
    end
  end

  // Assertion helper: clocks since the last counter step
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      step_gap_r <= 15'h0000;
    end else if (step) begin
      step_gap_r <= 15'h0000;
    end else begin
      step_gap_r <= step_gap_r + 15'h0001;
    end
  end

  a_no_reset_disabled: assert property (@(posedge CLK_SYS) disable iff (RST)
    WDT_ENABLE_N |=> !int_rst_r)
    else $error("reset while watchdog disabled");
  a_overflow_resets: assert property (@(posedge CLK_SYS) disable iff (RST)
    (wrap && !WDT_ENABLE_N && state_r == WDT_RUN) |=> int_rst_r)
    else $error("overflow gave no internal reset");
  a_pin_pulse_len: assert property (@(posedge CLK_SYS) disable iff (RST)
    $fell(RESET_PIN_OE) |-> pulse_len_r == `WDT_PULSE_CLOCKS)
    else $error("reset pin pulse length wrong");
  a_pin_pulse_max: assert property (@(posedge CLK_SYS) disable iff (RST)
    RESET_PIN_OE |-> pulse_len_r < `WDT_PULSE_CLOCKS)
    else $error("reset pin pulse too long");
  a_pulse_follows: assert property (@(posedge CLK_SYS) disable iff (RST)
    int_rst_r |-> RESET_PIN_OE)
    else $error("internal reset without pin pulse");
  a_pd_blocked: assert property (@(posedge CLK_SYS) disable iff (RST)
    !WDT_ENABLE_N && wr_pwr |=> !POWER_DOWN)
    else $error("power down set with watchdog on");
  a_load_clears_en: assert property (@(posedge CLK_SYS) disable iff (chip_rst)
    load && !wr_pwr |=> !pwrctl_r[`WDT_BIT_LOAD_EN])
    else $error("load enable not cleared");
  a_ignored_write: assert property (@(posedge CLK_SYS) disable iff (chip_rst)
    wr_count && !pwrctl_r[`WDT_BIT_LOAD_EN] && !step |=> count == $past(count))
    else $error("counter changed without load enable");
  a_loaded_value: assert property (@(posedge CLK_SYS) disable iff (chip_rst)
    load |=> count == $past(SFR_WDATA))
    else $error("counter load wrong");
  a_step_only_wrap: assert property (@(posedge CLK_SYS) disable iff (chip_rst)
    !step && !load |=> count == $past(count))
    else $error("counter moved without prescaler wrap");
  a_step_period: assert property (@(posedge CLK_SYS) disable iff (RST)
    step == (step_gap_r == `WDT_STEP_GAP))
    else $error("counter step spacing wrong");
  a_int_reset_clears: assert property (@(posedge CLK_SYS) disable iff (RST)
    int_rst_r |-> count == `WDT_COUNT_RESET && pwrctl_r == `WDT_PWRCTL_RESET)
    else $error("internal reset left state behind");
  a_prescale_runs: assert property (@(posedge CLK_SYS) disable iff (chip_rst)
    tick |=> prescale_r == $past(prescale_r) + 11'h001)
    else $error("prescaler did not advance");
  a_read_count: assert property (@(posedge CLK_SYS) disable iff (RST)
    SFR_RD && SFR_ADDR == `WDT_ADDR_COUNT |=> SFR_RDATA == $past(count))
    else $error("counter read wrong");
  a_disabled_no_pin: assert property (@(posedge CLK_SYS) disable iff (RST)
    WDT_ENABLE_N && state_r == WDT_RUN |=> !RESET_PIN_OE)
    else $error("pin pulse while watchdog disabled");
  a_pd_stays_low: assert property (@(posedge CLK_SYS) disable iff (RST)
    !WDT_ENABLE_N && !POWER_DOWN |=> !POWER_DOWN)
    else $error("power down rose with watchdog on");
  a_pd_allowed_off: assert property (@(posedge CLK_SYS) disable iff (chip_rst)
    WDT_ENABLE_N && wr_pwr |=> POWER_DOWN == $past(SFR_WDATA[`WDT_BIT_PWR_DOWN]))
    else $error("power down write lost with watchdog off");
endmodule
`default_nettype wire

// ---- wdt_cfg.svh ----
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_ADDR_COUNT 8'hFF
`define WDT_ADDR_PWRCTL 8'h87
`define WDT_BIT_LOAD_EN 4
`define WDT_BIT_PWR_DOWN 1
`define WDT_BIT_IDLE 0
`define WDT_OSC_DIV 4'hB
`define WDT_PRESCALE_MAX 11'h7FF
`define WDT_COUNT_RESET 8'h00
`define WDT_PWRCTL_RESET 8'h00
`define WDT_PULSE_MCYCLES 2'h3
`define WDT_PULSE_CLOCKS 6'h24
`define WDT_STEP_GAP 15'h5FFF
`endif

// ---- wdt_pkg.sv ----
`default_nettype none
package wdt_pkg;
  typedef enum logic [1:0] {WDT_RUN, WDT_PULSE} wdt_state_t;
endpackage
`default_nettype wire

// ---- wdt_count_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_count_reg
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic inc,
  output logic [7:0] count,
  output logic wrap
);
  logic [7:0] count_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= `WDT_COUNT_RESET;
    end else if (load) begin
      count_r <= load_data;
    end else if (inc) begin
      count_r <= count_r + 8'h01;
    end
  end
  assign count = count_r;
  assign wrap = inc && !load && (count_r == 8'hFF);
endmodule
`default_nettype wire

// ---- wdt_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic en_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic idle, pdown, rst_int, pin_o, pin_oe;
  logic seen;
  int mismatches = 0;
  int checks = 0;
  int n;
  always #2 clk_sys = ~clk_sys;
  wdt_top dut_u (.CLK_SYS(clk_sys), .RST(rst), .WDT_ENABLE_N(en_n), .SFR_WR(wr),
    .SFR_RD(rd), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
    .IDLE_MODE(idle), .POWER_DOWN(pdown), .RESET_INTERNAL(rst_int),
    .RESET_PIN_O(pin_o), .RESET_PIN_OE(pin_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_sys);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    rd = 1'b1;
    addr = a;
    @(negedge clk_sys);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #240000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    rd_reg(8'hFF, 8'h00);
    rd_reg(8'h87, 8'h00);
    rd_reg(8'h10, 8'h00);
    wr_reg(8'hFF, 8'h5A);
    rd_reg(8'hFF, 8'h00);
    wr_reg(8'h87, 8'h10);
    rd_reg(8'h87, 8'h10);
    wr_reg(8'hFF, 8'h5A);
    rd_reg(8'hFF, 8'h5A);
    rd_reg(8'h87, 8'h00);
    wr_reg(8'h87, 8'h02);
    rd_reg(8'h87, 8'h00);
    chk({7'h00, pdown}, 8'h00);
    en_n = 1'b1;
    wr_reg(8'h87, 8'h02);
    chk({7'h00, pdown}, 8'h01);
    wr_reg(8'h87, 8'h10);
    wr_reg(8'hFF, 8'hFF);
    seen = 1'b0;
    repeat (25000) begin
      @(negedge clk_sys);
      seen = seen | (rst_int !== 1'b0) | (pin_oe !== 1'b0);
    end
    chk({7'h00, seen}, 8'h00);
    en_n = 1'b0;
    wr_reg(8'h87, 8'hFF);
    chk({7'h00, idle}, 8'h01);
    chk({7'h00, pdown}, 8'h00);
    wr_reg(8'hFF, 8'hFF);
    rd_reg(8'hFF, 8'hFF);
    rd_reg(8'h87, 8'hED);
    n = 0;
    while (rst_int !== 1'b1 && n < 24700) begin
      @(negedge clk_sys);
      n++;
    end
    chk({7'h00, rst_int}, 8'h01);
    n = 0;
    while (pin_oe === 1'b1 && n < 50) begin
      chk({7'h00, pin_o}, 8'h01);
      @(negedge clk_sys);
      n++;
    end
    chk(8'(n), 8'h24);
    rd_reg(8'hFF, 8'h00);
    rd_reg(8'h87, 8'h00);
    chk({7'h00, idle}, 8'h00);
    wr_reg(8'h87, 8'h10);
    wr_reg(8'hFF, 8'h33);
    rd_reg(8'hFF, 8'h33);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rd_reg(8'hFF, 8'h00);
    rd_reg(8'h87, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
